// file: logic/mfr_addr_decode.sv
// Purpose: maps a bus byte address to a register kind and storage entry
// Assumes: byte address is four times the printed index
// Notes:   purely combinational, shared by the write and read paths
`timescale 1ns/1ps
`default_nettype none
module mfr_addr_decode
(
	input  wire logic [mfr_pkg::ADDR_W-1:0]  byte_addr,
	output var  mfr_pkg::mfr_kind_t          kind,
	output logic [mfr_pkg::ENTRY_W-1:0]      entry
);
	import mfr_pkg::*;

	logic [OFS_W-1:0] ofs;
	logic             aligned;

	// ------------------------------------------------------------
	// index extraction
	// ------------------------------------------------------------
	assign ofs     = byte_addr[OFS_W+1:2];
	assign aligned = (byte_addr[1:0] == 2'h0) && (byte_addr[ADDR_W-1:OFS_W+2] == '0);
	assign entry   = ofs[OFS_W-1:1];

	// odd indices, gaps and a0..ff all fall to none
	always_comb
	begin
		kind = KIND_NONE;
		if (aligned && !ofs[0] && (ofs < OFS_FIRST_UNASSIGNED))
		begin
			case (ofs)
				OFS_MASTER_RESET_IDENT:                                   kind = KIND_MASTER_RESET_IDENT;
				OFS_MASTER_STATUS, OFS_LINE_FRAMER_STATUS, OFS_LINE_FRAMER_INFO,
				OFS_LOOP_CMD_STATUS_ONE, OFS_LOOP_CMD_STATUS_TWO,
				OFS_TESTER_BIT_COUNT_LOW, OFS_TESTER_BIT_COUNT_HIGH,
				OFS_TESTER_ERR_COUNT_LOW, OFS_TESTER_ERR_COUNT_HIGH,
				OFS_LINK_STATUS, OFS_FAR_END_CODE_STATUS:                 kind = KIND_RO;
				OFS_BIPOLAR_VIOLATION_COUNT, OFS_EXCESS_ZERO_COUNT, OFS_FRAME_ERROR_COUNT,
				OFS_PARITY_BIT_ERROR_COUNT, OFS_CBIT_PARITY_ERROR_COUNT,
				OFS_FAR_END_BLOCK_ERR_COUNT:                              kind = KIND_RO;
				OFS_LINK_RX_FIFO_PORT:                                    kind = KIND_RO;
				OFS_LINK_TX_FIFO_PORT:                                    kind = KIND_WO;
				OFS_MASTER_CONFIG_ONE, OFS_MASTER_CONFIG_TWO, OFS_MASTER_CONFIG_THREE,
				OFS_MASTER_STATUS_IRQ_MASK, OFS_FACTORY_TEST_REG, OFS_LINE_FRAMER_CONTROL,
				OFS_LINE_FRAMER_IRQ_MASK, OFS_LINE_ERROR_INSERT,
				OFS_MID_RATE_CONTROL_ONE, OFS_MID_RATE_CONTROL_TWO,
				OFS_MID_RATE_STATUS_ONE, OFS_MID_RATE_STATUS_TWO,
				OFS_TRIB_RX_ALARM_GEN_ONE, OFS_TRIB_RX_ALARM_GEN_TWO,
				OFS_TRIB_TX_ALARM_GEN_ONE, OFS_TRIB_TX_ALARM_GEN_TWO,
				OFS_TRIB_LINE_LOOP_ONE, OFS_TRIB_LINE_LOOP_TWO,
				OFS_TRIB_DIAG_LOOP_ONE, OFS_TRIB_DIAG_LOOP_TWO,
				OFS_LOOP_COMMAND_ONE, OFS_LOOP_COMMAND_TWO,
				OFS_RX_DROP_PORT_SELECT, OFS_TX_INSERT_PORT_SELECT,
				OFS_ERROR_TESTER_MUX, OFS_ERROR_TESTER_CONTROL,
				OFS_REPEAT_PATTERN_LOW, OFS_REPEAT_PATTERN_HIGH,
				OFS_LINK_CONTROLLER_CONTROL, OFS_LINK_STATUS_IRQ_MASK,
				OFS_FAR_END_CODE_CONTROL:                                 kind = KIND_RW;
				default:                                                  kind = KIND_NONE;
			endcase
		end
	end

endmodule
`default_nettype wire

// file: logic/mfr_edge_pulse.sv
// Purpose: one-cycle pulse on each rising edge of the control levels
// Assumes: levels come from flip-flops in the same clock domain
// Notes:   a level held high gives one pulse only; it must drop before another
`timescale 1ns/1ps
`default_nettype none
module mfr_edge_pulse
(
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic [mfr_pkg::PULSE_N-1:0]  level,
	output logic [mfr_pkg::PULSE_N-1:0]       pulse
);
	import mfr_pkg::*;

	mfr_edge_state_t    state;
	mfr_edge_state_t    next_state;
	logic [PULSE_N-1:0] next_pulse_bit;

	// ------------------------------------------------------------
	// per-bit rise detect
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < PULSE_N; gi++)
		begin : g_bit
			assign next_pulse_bit[gi] = level[gi] & ~state.prev[gi];
		end
	endgenerate

	// next state
	always_comb
	begin
		next_state       = state;
		next_state.prev  = level;
		next_state.pulse = next_pulse_bit;
	end

	// registered state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= '0;
		else
			state <= next_state;
	end

	assign pulse = state.pulse;

endmodule
`default_nettype wire

// file: logic/mfr_pkg.sv
// Purpose: shared constants and types for the mux framer register bank
// Assumes: 32-bit AXI4-Lite, 16-bit registers in the low half of each word
// Notes:   printed offsets are register indices; byte address is four times the index
package mfr_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int          ADDR_W    = 12;
	localparam int          DATA_W    = 32;
	localparam int          STRB_W    = DATA_W / 8;
	localparam int          REG_W     = 16;
	localparam int          NUM_ENTRY = 80;       // offsets 00..9e, two per entry
	localparam int          ENTRY_W   = 7;
	localparam int          OFS_W     = 8;
	localparam logic [1:0]  RESP_OKAY = 2'h0;

	// ------------------------------------------------------------
	// register indices as printed
	// ------------------------------------------------------------
	localparam logic [OFS_W-1:0] OFS_MASTER_RESET_IDENT      = 8'h00;
	localparam logic [OFS_W-1:0] OFS_MASTER_CONFIG_ONE       = 8'h02;
	localparam logic [OFS_W-1:0] OFS_MASTER_CONFIG_TWO       = 8'h04;
	localparam logic [OFS_W-1:0] OFS_MASTER_CONFIG_THREE     = 8'h06;
	localparam logic [OFS_W-1:0] OFS_MASTER_STATUS           = 8'h08;
	localparam logic [OFS_W-1:0] OFS_MASTER_STATUS_IRQ_MASK  = 8'h0a;
	localparam logic [OFS_W-1:0] OFS_FACTORY_TEST_REG        = 8'h0c;
	localparam logic [OFS_W-1:0] OFS_LINE_FRAMER_CONTROL     = 8'h10;
	localparam logic [OFS_W-1:0] OFS_LINE_FRAMER_STATUS      = 8'h12;
	localparam logic [OFS_W-1:0] OFS_LINE_FRAMER_IRQ_MASK    = 8'h14;
	localparam logic [OFS_W-1:0] OFS_LINE_FRAMER_INFO        = 8'h16;
	localparam logic [OFS_W-1:0] OFS_LINE_ERROR_INSERT       = 8'h18;
	localparam logic [OFS_W-1:0] OFS_BIPOLAR_VIOLATION_COUNT = 8'h20;
	localparam logic [OFS_W-1:0] OFS_EXCESS_ZERO_COUNT       = 8'h22;
	localparam logic [OFS_W-1:0] OFS_FRAME_ERROR_COUNT       = 8'h24;
	localparam logic [OFS_W-1:0] OFS_PARITY_BIT_ERROR_COUNT  = 8'h26;
	localparam logic [OFS_W-1:0] OFS_CBIT_PARITY_ERROR_COUNT = 8'h28;
	localparam logic [OFS_W-1:0] OFS_FAR_END_BLOCK_ERR_COUNT = 8'h2a;
	localparam logic [OFS_W-1:0] OFS_MID_RATE_CONTROL_ONE    = 8'h30;
	localparam logic [OFS_W-1:0] OFS_MID_RATE_CONTROL_TWO    = 8'h32;
	localparam logic [OFS_W-1:0] OFS_MID_RATE_STATUS_ONE     = 8'h34;
	localparam logic [OFS_W-1:0] OFS_MID_RATE_STATUS_TWO     = 8'h36;
	localparam logic [OFS_W-1:0] OFS_TRIB_RX_ALARM_GEN_ONE   = 8'h40;
	localparam logic [OFS_W-1:0] OFS_TRIB_RX_ALARM_GEN_TWO   = 8'h42;
	localparam logic [OFS_W-1:0] OFS_TRIB_TX_ALARM_GEN_ONE   = 8'h44;
	localparam logic [OFS_W-1:0] OFS_TRIB_TX_ALARM_GEN_TWO   = 8'h46;
	localparam logic [OFS_W-1:0] OFS_TRIB_LINE_LOOP_ONE      = 8'h50;
	localparam logic [OFS_W-1:0] OFS_TRIB_LINE_LOOP_TWO      = 8'h52;
	localparam logic [OFS_W-1:0] OFS_TRIB_DIAG_LOOP_ONE      = 8'h54;
	localparam logic [OFS_W-1:0] OFS_TRIB_DIAG_LOOP_TWO      = 8'h56;
	localparam logic [OFS_W-1:0] OFS_LOOP_COMMAND_ONE        = 8'h58;
	localparam logic [OFS_W-1:0] OFS_LOOP_COMMAND_TWO        = 8'h5a;
	localparam logic [OFS_W-1:0] OFS_LOOP_CMD_STATUS_ONE     = 8'h5c;
	localparam logic [OFS_W-1:0] OFS_LOOP_CMD_STATUS_TWO     = 8'h5e;
	localparam logic [OFS_W-1:0] OFS_RX_DROP_PORT_SELECT     = 8'h60;
	localparam logic [OFS_W-1:0] OFS_TX_INSERT_PORT_SELECT   = 8'h62;
	localparam logic [OFS_W-1:0] OFS_ERROR_TESTER_MUX        = 8'h6e;
	localparam logic [OFS_W-1:0] OFS_ERROR_TESTER_CONTROL    = 8'h70;
	localparam logic [OFS_W-1:0] OFS_REPEAT_PATTERN_LOW      = 8'h72;
	localparam logic [OFS_W-1:0] OFS_REPEAT_PATTERN_HIGH     = 8'h76;
	localparam logic [OFS_W-1:0] OFS_TESTER_BIT_COUNT_LOW    = 8'h78;
	localparam logic [OFS_W-1:0] OFS_TESTER_BIT_COUNT_HIGH   = 8'h7a;
	localparam logic [OFS_W-1:0] OFS_TESTER_ERR_COUNT_LOW    = 8'h7c;
	localparam logic [OFS_W-1:0] OFS_TESTER_ERR_COUNT_HIGH   = 8'h7e;
	localparam logic [OFS_W-1:0] OFS_LINK_CONTROLLER_CONTROL = 8'h80;
	localparam logic [OFS_W-1:0] OFS_LINK_RX_FIFO_PORT       = 8'h82;
	localparam logic [OFS_W-1:0] OFS_LINK_TX_FIFO_PORT       = 8'h84;
	localparam logic [OFS_W-1:0] OFS_LINK_STATUS             = 8'h86;
	localparam logic [OFS_W-1:0] OFS_LINK_STATUS_IRQ_MASK    = 8'h88;
	localparam logic [OFS_W-1:0] OFS_FAR_END_CODE_CONTROL    = 8'h90;
	localparam logic [OFS_W-1:0] OFS_FAR_END_CODE_STATUS     = 8'h92;
	localparam logic [OFS_W-1:0] OFS_FIRST_UNASSIGNED        = 8'ha0;

	// ------------------------------------------------------------
	// master reset and ident fields
	// ------------------------------------------------------------
	localparam int             SOFT_RST_BIT       = 0;
	localparam int             TRIB_FLUSH_BIT     = 1;
	localparam int             MID_RESYNC_BIT     = 2;
	localparam int             LINE_RESYNC_BIT    = 3;
	localparam int             CTRL_FIELD_W       = 4;
	localparam int             REV_LSB            = 8;
	localparam int             REV_W              = 8;
	localparam int             PULSE_N            = 3;
	localparam logic [REG_W-1:0] REG_RESET        = 16'h0000;

	// soft reset hold time kept by the host
	localparam int             SOFT_RST_MIN_NS    = 100;
	localparam int             CLK_PERIOD_NS      = 4;
	localparam int             SOFT_RST_MIN_CYC   = (SOFT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		KIND_NONE = 3'h0,
		KIND_RW   = 3'h1,
		KIND_RO   = 3'h2,
		KIND_WO   = 3'h3,
		KIND_MASTER_RESET_IDENT = 3'h4
	} mfr_kind_t;

	typedef enum logic [0:0]
	{
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} mfr_wr_state_t;

	typedef enum logic [0:0]
	{
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} mfr_rd_state_t;

	typedef struct packed
	{
		mfr_wr_state_t                     wst;
		mfr_rd_state_t                     rdst;
		logic                              aw_got;
		logic                              w_got;
		logic [ADDR_W-1:0]                 aw_addr;
		logic [DATA_W-1:0]                 w_data;
		logic [STRB_W-1:0]                 w_strb;
		logic                              awready;
		logic                              wready;
		logic                              bvalid;
		logic [1:0]                        bresp;
		logic                              arready;
		logic                              rvalid;
		logic [1:0]                        rresp;
		logic [DATA_W-1:0]                 rdata;
		logic [NUM_ENTRY-1:0][REG_W-1:0]   regs;
		logic                              tx_push;
		logic [REG_W-1:0]                  tx_data;
		logic                              rx_pop;
		logic                              force_ones;
	} mfr_state_t;

	typedef struct packed
	{
		logic [PULSE_N-1:0] prev;
		logic [PULSE_N-1:0] pulse;
	} mfr_edge_state_t;

endpackage

// file: logic/mfr_reg_bank.sv
// Purpose: host register bank of the line framer and multiplexer, reached over AXI4-Lite
// Assumes: other blocks supply read-only values and consume configuration and pulses
// Notes:   every top output comes from a flip-flop; soft reset holds the bank at zero but for its own bit
//
// Notes on behaviour
// - soft reset bit set returns every internal register to all zeros except the soft reset bit itself
// - while soft reset is set, line and tributary outputs send all ones
// - reset applies when soft reset bit or the hardware reset is active
// - upper byte of master register reads revision code; writes there do nothing
// - offset zero: bit0 soft reset, bit1 fifo flush, bit2/3 resyncs, bits4-7 unused
// - even listed offsets decode; gaps and a0 through ff are unassigned
// - performance error counters 20 through 2a are read-only, writes ignored
// - transmit link fifo port 84 write-only, receive port 82 read-only
// - rising edge of fifo flush bit flushes tributary receive fifos once
// - rising edge of a resync bit resynchronises its framers once
`timescale 1ns/1ps
`default_nettype none
module mfr_reg_bank
#(
	parameter logic [7:0] REVISION_CODE = 8'h5a  // arbitrary value
)
(
	input  wire logic                                          aclk,
	input  wire logic                                          aresetn,
	// write address channel
	input  wire logic [mfr_pkg::ADDR_W-1:0]                    s_axi_awaddr,
	input  wire logic [2:0]                                    s_axi_awprot,
	input  wire logic                                          s_axi_awvalid,
	output logic                                               s_axi_awready,
	// write data channel
	input  wire logic [mfr_pkg::DATA_W-1:0]                    s_axi_wdata,
	input  wire logic [mfr_pkg::STRB_W-1:0]                    s_axi_wstrb,
	input  wire logic                                          s_axi_wvalid,
	output logic                                               s_axi_wready,
	// write response channel
	output logic [1:0]                                         s_axi_bresp,
	output logic                                               s_axi_bvalid,
	input  wire logic                                          s_axi_bready,
	// read address channel
	input  wire logic [mfr_pkg::ADDR_W-1:0]                    s_axi_araddr,
	input  wire logic [2:0]                                    s_axi_arprot,
	input  wire logic                                          s_axi_arvalid,
	output logic                                               s_axi_arready,
	// read data channel
	output logic [mfr_pkg::DATA_W-1:0]                         s_axi_rdata,
	output logic [1:0]                                         s_axi_rresp,
	output logic                                               s_axi_rvalid,
	input  wire logic                                          s_axi_rready,
	// block side
	input  wire logic [mfr_pkg::NUM_ENTRY-1:0][mfr_pkg::REG_W-1:0] status_value,
	output logic [mfr_pkg::NUM_ENTRY-1:0][mfr_pkg::REG_W-1:0]  cfg_value,
	output logic                                               force_all_ones,
	output logic                                               trib_fifo_flush,
	output logic                                               mid_rate_resync,
	output logic                                               line_framer_resync,
	output logic                                               link_tx_push,
	output logic [mfr_pkg::REG_W-1:0]                          link_tx_data,
	output logic                                               link_rx_pop
);
	import mfr_pkg::*;

	localparam logic [ENTRY_W-1:0] MASTER_RESET_IDENT_ENTRY  = OFS_MASTER_RESET_IDENT[OFS_W-1:1];
	localparam logic [ENTRY_W-1:0] RXFIFO_ENTRY = OFS_LINK_RX_FIFO_PORT[OFS_W-1:1];

	mfr_state_t           state;
	mfr_state_t           next_state;
	mfr_kind_t            wr_kind;
	logic [ENTRY_W-1:0]   wr_entry;
	mfr_kind_t            rd_kind;
	logic [ENTRY_W-1:0]   rd_entry;
	logic [DATA_W-1:0]    rd_word;
	logic [PULSE_N-1:0]   pulse_level;
	logic [PULSE_N-1:0]   pulse_out;
	logic                 wr_fire;
	logic                 rd_fire;

	// ------------------------------------------------------------
	// address decode for both paths
	// ------------------------------------------------------------

	// the write path decodes the captured address, not the live bus
	mfr_addr_decode u_wr_decode
	(
		.byte_addr (state.aw_addr),
		.kind      (wr_kind),
		.entry     (wr_entry)
	);

	// the read path decodes the offered address in its handshake cycle
	mfr_addr_decode u_rd_decode
	(
		.byte_addr (s_axi_araddr),
		.kind      (rd_kind),
		.entry     (rd_entry)
	);

	// ------------------------------------------------------------
	// read data selection
	// ------------------------------------------------------------

	// master word: revision on top, control nibble low, unused bits read zero
	always_comb
	begin
		rd_word = '0;
		case (rd_kind)
			KIND_MASTER_RESET_IDENT:
				rd_word = {{(DATA_W-REG_W){1'b0}}, REVISION_CODE,
					{(REV_LSB-CTRL_FIELD_W){1'b0}},
					state.regs[MASTER_RESET_IDENT_ENTRY][CTRL_FIELD_W-1:0]};
			KIND_RW:
				rd_word = {{(DATA_W-REG_W){1'b0}}, state.regs[rd_entry]};
			KIND_RO:
				rd_word = {{(DATA_W-REG_W){1'b0}}, status_value[rd_entry]};
			KIND_WO:
				rd_word = '0;  // transmit fifo port has nothing to read back
			default:
				rd_word = '0;
		endcase
	end

	// ------------------------------------------------------------
	// handshake terms
	// ------------------------------------------------------------
	assign wr_fire = (state.wst == WR_IDLE) && state.aw_got && state.w_got;
	assign rd_fire = (state.rdst == RD_IDLE) && state.arready && s_axi_arvalid;

	// ------------------------------------------------------------
	// next state of the whole bank
	// ------------------------------------------------------------

	// address and data are captured independently so either may come first
	always_comb
	begin
		next_state         = state;
		next_state.tx_push = 1'b0;
		next_state.rx_pop  = 1'b0;
		next_state.bresp   = RESP_OKAY;
		next_state.rresp   = RESP_OKAY;

		// write address capture
		if (state.awready && s_axi_awvalid)
		begin
			next_state.aw_got  = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end

		// write data capture
		if (state.wready && s_axi_wvalid)
		begin
			next_state.w_got  = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end

		// apply a complete write, then answer
		if (wr_fire)
		begin
			next_state.wst    = WR_RESP;
			next_state.bvalid = 1'b1;
			next_state.aw_got = 1'b0;
			next_state.w_got  = 1'b0;
			case (wr_kind)
				KIND_RW:
				begin
					for (int b = 0; b < REG_W / 8; b++)
					begin
						if (state.w_strb[b])
							next_state.regs[wr_entry][b*8 +: 8] = state.w_data[b*8 +: 8];
					end
				end
				KIND_MASTER_RESET_IDENT:
				begin
					// only the control nibble is stored; the revision byte ignores writes
					if (state.w_strb[0])
						next_state.regs[MASTER_RESET_IDENT_ENTRY][CTRL_FIELD_W-1:0] =
							state.w_data[CTRL_FIELD_W-1:0];
				end
				KIND_WO:
				begin
					next_state.tx_push = 1'b1;
					next_state.tx_data = state.w_data[REG_W-1:0];
				end
				KIND_RO:
				begin
					// counters and status keep their value
				end
				default:
				begin
					// unassigned: no side effect
				end
			endcase
		end

		// write response retires on bready
		if (state.bvalid && s_axi_bready)
		begin
			next_state.bvalid = 1'b0;
			next_state.wst    = WR_IDLE;
		end

		// read: data is sampled at the address handshake
		if (rd_fire)
		begin
			next_state.rdst   = RD_RESP;
			next_state.rvalid = 1'b1;
			next_state.rdata  = rd_word;
			if ((rd_kind == KIND_RO) && (rd_entry == RXFIFO_ENTRY))
				next_state.rx_pop = 1'b1;
		end

		// read response retires on rready
		if (state.rvalid && s_axi_rready)
		begin
			next_state.rvalid = 1'b0;
			next_state.rdst   = RD_IDLE;
		end

		// soft reset clears the bank every cycle it stays set, so a write to any other
		// register during it is lost; only the bit itself survives so the host can drop it
		if (next_state.regs[MASTER_RESET_IDENT_ENTRY][SOFT_RST_BIT])
		begin
			next_state.regs                            = '0;
			next_state.regs[MASTER_RESET_IDENT_ENTRY][SOFT_RST_BIT]  = 1'b1;
			next_state.tx_push                         = 1'b0;
		end
		next_state.force_ones = next_state.regs[MASTER_RESET_IDENT_ENTRY][SOFT_RST_BIT];

		// ready flags follow from the state they lead into
		next_state.awready = (next_state.wst == WR_IDLE) && !next_state.aw_got;
		next_state.wready  = (next_state.wst == WR_IDLE) && !next_state.w_got;
		next_state.arready = (next_state.rdst == RD_IDLE);
	end

	// ------------------------------------------------------------
	// registered state
	// ------------------------------------------------------------

	// the hardware reset clears the bank; the all-ones drive is held on through it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state            <= '0;
			state.force_ones <= 1'b1;
		end
		else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// rising-edge pulses of control bits 1 to 3 (flush and resyncs)
	// ------------------------------------------------------------
	assign pulse_level = state.regs[MASTER_RESET_IDENT_ENTRY][LINE_RESYNC_BIT:TRIB_FLUSH_BIT];

	mfr_edge_pulse u_edge
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (pulse_level),
		.pulse   (pulse_out)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready      = state.awready;
	assign s_axi_wready       = state.wready;
	assign s_axi_bvalid       = state.bvalid;
	assign s_axi_bresp        = state.bresp;
	assign s_axi_arready      = state.arready;
	assign s_axi_rvalid       = state.rvalid;
	assign s_axi_rdata        = state.rdata;
	assign s_axi_rresp        = state.rresp;
	assign cfg_value          = state.regs;
	assign force_all_ones     = state.force_ones;
	assign trib_fifo_flush    = pulse_out[TRIB_FLUSH_BIT-1];
	assign mid_rate_resync    = pulse_out[MID_RESYNC_BIT-1];
	assign line_framer_resync = pulse_out[LINE_RESYNC_BIT-1];
	assign link_tx_push       = state.tx_push;
	assign link_tx_data       = state.tx_data;
	assign link_rx_pop        = state.rx_pop;

endmodule
`default_nettype wire

// file: test/mfr_host.sv
// Purpose: host model on AXI4-Lite. Assumes: one transfer at a time. Notes: byte address is 4 x index.
`timescale 1ns/1ps
`default_nettype none
module mfr_host
(
	input wire logic        aclk,
	input wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	output logic [11:0]     s_axi_awaddr, s_axi_araddr,
	output logic [31:0]     s_axi_wdata,
	output logic            s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready
);
	initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
	// address and data offered together, each dropped once taken; bready held until the answer
	task automatic wr(input logic [7:0] ofs, input logic [15:0] v);
		@(posedge aclk);
		s_axi_awaddr <= {2'h0, ofs, 2'h0};
		s_axi_wdata <= {16'h0, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ofs, output logic [31:0] v);
		@(posedge aclk);
		s_axi_araddr <= {2'h0, ofs, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: test/mfr_reg_bank_chk.sv
// Purpose: port checks of mfr_reg_bank. Assumes: one clock. Notes: bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module mfr_chk
	import mfr_pkg::*;
#(parameter logic [7:0] REVISION_CODE = 8'h00)
(
	input wire logic                      aclk,
	input wire logic                      aresetn,
	input wire logic [ADDR_W-1:0]         s_axi_araddr,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [DATA_W-1:0]         s_axi_rdata,
	input wire logic [NUM_ENTRY-1:0][15:0] cfg_value,
	input wire logic                      force_all_ones,
	input wire logic                      trib_fifo_flush,
	input wire logic                      line_framer_resync,
	input wire logic                      mid_rate_resync,
	input wire logic                      link_rx_pop
);
	// soft reset bit as stored; $past gives one cycle of slack on its side effects
	wire logic take = s_axi_arvalid && s_axi_arready;
	wire logic sb = cfg_value[0][0];
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_soft_clear: assert property (sb && $past(sb) |-> {cfg_value[NUM_ENTRY-1:1], cfg_value[0][15:1]} == '0)
		else $error("soft reset left data");
	a_force_soft: assert property (sb && $past(sb) |-> force_all_ones)
		else $error("no ones in soft reset");
	a_force_or: assert property ($past(aresetn) && !sb && !$past(sb) |-> !force_all_ones)
		else $error("ones without reset");
	a_flush_edge: assert property (trib_fifo_flush |-> $past(cfg_value[0][1]) && !$past(cfg_value[0][1], 2))
		else $error("flush without edge");
	a_resync_once: assert property ($rose(cfg_value[0][3]) |=> line_framer_resync ##1 !line_framer_resync)
		else $error("resync pulse wrong");
	a_mid_resync: assert property ($rose(cfg_value[0][2]) |=> mid_rate_resync ##1 !mid_rate_resync)
		else $error("mid resync pulse wrong");
	a_rev_read: assert property (take && s_axi_araddr == '0 |=> s_axi_rdata[15:8] == REVISION_CODE)
		else $error("revision wrong");
	a_free_read: assert property (take && s_axi_araddr >= 12'h280 |=> s_axi_rdata == '0)
		else $error("unassigned not zero");
	a_rx_pop: assert property (take && s_axi_araddr == 12'h208 |=> link_rx_pop)
		else $error("no pop");
	c_flush: cover property (trib_fifo_flush);
	c_soft: cover property (force_all_ones && sb);
	c_pop: cover property (link_rx_pop);
endmodule
`default_nettype wire

// file: test/test_mfr_reg_bank.sv
// Purpose: random and corner tests of mfr_reg_bank. Assumes: host model. Notes: seed 80.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module test_mfr_reg_bank
	import mfr_pkg::*;
;
	localparam logic [7:0] REV = 8'h3c; // arbitrary value
	logic aclk = 0, aresetn = 0, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, force_all_ones, link_tx_push, link_rx_pop;
	logic trib_fifo_flush, mid_rate_resync, line_framer_resync;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [NUM_ENTRY-1:0][15:0] status_value, cfg_value;
	logic [15:0] link_tx_data, v, sv, txd;
	int miscompares = 0, total_checks = 0, cyc = 0, i;
	mfr_reg_bank #(.REVISION_CODE(REV)) uut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf), .*);
	mfr_host host (.*);
	always #2 aclk = ~aclk;
	// last word pushed toward the transmit link fifo
	always @(posedge aclk)
		if (link_tx_push) txd <= link_tx_data;
	// a hang counts as a mismatch
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			complete_run();
		end
	end
	task automatic wr_rd(input logic [7:0] ofs, input logic [15:0] w, input logic [15:0] e);
		host.wr(ofs, w);
		host.rd(ofs, d);
		`CHK(d, {16'h0, e})
		`CHK({s_axi_bresp, s_axi_rresp}, 4'h0)
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		status_value = '0;
		v = 16'($urandom(80));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			v = 16'($urandom);
			sv = 16'($urandom);
			status_value[16] <= sv;
			status_value[65] <= ~sv;
			wr_rd(8'h02, v, v);
			wr_rd(8'h20, v, sv);
			wr_rd(8'h82, v, ~sv);
			wr_rd(8'h84, v, 16'h0);
			`CHK(txd, v)
			wr_rd(8'ha0 + 8'(2 * ($urandom % 48)), v, 16'h0);
		end
		$display("random map test done");
		wr_rd(8'h00, 16'hff0e, {REV, 8'h0e});
		wr_rd(8'h00, 16'h0000, {REV, 8'h00});
		wr_rd(8'h00, 16'h0002, {REV, 8'h02});
		wr_rd(8'h02, 16'h1234, 16'h1234);
		wr_rd(8'h00, 16'h0001, {REV, 8'h01});
		`CHK(force_all_ones, 1'b1)
		wr_rd(8'h02, 16'hbeef, 16'h0000);
		repeat (SOFT_RST_MIN_CYC) @(posedge aclk);
		wr_rd(8'h00, 16'h0000, {REV, 8'h00});
		`CHK(force_all_ones, 1'b0)
		$display("soft reset test done");
		wr_rd(8'h02, v, v);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		`CHK(force_all_ones, 1'b1)
		aresetn <= 1'b1;
		host.rd(8'h02, d);
		`CHK(d, 32'h0)
		$display("hardware reset test done");
		complete_run();
	end
endmodule
bind mfr_reg_bank mfr_chk #(.REVISION_CODE(REVISION_CODE)) chk (.*);
`default_nettype wire
